// [dv/ubg_properties.sv]
`timescale 1ns/10ps
module ubg_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // rate ticks
    input wire logic tx_rate_tick,
    input wire logic rx_rate_tick
);
    logic [15:0] gap;
    logic [15:0] next_gap;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // longest legal period is 64 * 256, so the counter never needs more
    always_comb next_gap = (!rst_n || tx_rate_tick) ? 16'h0000 : gap + 16'h0001;
    always_ff @(posedge clk) gap <= next_gap;

    ticks_shared_a: assert property (tx_rate_tick == rx_rate_tick)
        else $error("tx and rx ticks differ");
    tick_single_a: assert property (tx_rate_tick |=> !tx_rate_tick)
        else $error("tick longer than one cycle");
    tick_min_gap_a: assert property (tx_rate_tick |=> !tx_rate_tick[*8] ##1 !tx_rate_tick[*7])
        else $error("tick period below 16 cycles");
    tick_max_gap_a: assert property (gap <= 16'h4000)
        else $error("tick period above 16384 cycles");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped early");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid)
        else $error("no write response after write");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read response after read");

    cover property (tx_rate_tick);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
endmodule : ubg_properties

bind ubg_top ubg_properties u_props (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .tx_rate_tick, .rx_rate_tick);

// [dv/ubg_tb_top.sv]
`timescale 1ns/10ps
module ubg_tb_top;
    import ubg_pkg::*;
    logic        clk, rst_n;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, tx_rate_tick, rx_rate_tick;
    int          failures, num_checks;
    // speed select, divisor, expected period in cycles
    int          cfg [4][3] = '{'{1, 0, 16}, '{0, 3, 256}, '{1, 255, 4096}, '{0, 255, 16384}};

    ubg_top DUT (.clk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_rate_tick, .rx_rate_tick);

    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic hang();
        failures++;
        $display("FAIL wait expected answer seen timeout");
        finish_test();
    endtask : hang

    // handshakes are sampled at the falling edge, acted on at the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        int i;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(negedge clk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) break;
        end
        s_axi_bready <= 1'b0;
        if (i == 50) hang();
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar, v;
        logic [31:0] d;
        logic [1:0] r;
        int i;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(negedge clk);
            ar = s_axi_arvalid & s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (v) break;
        end
        s_axi_rready <= 1'b0;
        if (i == 50) hang();
        chk("rdata", ed, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask : rd

    // first tick closes any period mixed with a settings change, second is measured
    task automatic per(input logic [31:0] e);
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (!tx_rate_tick && n < 20000);
            if (n >= 20000) hang();
        end
        chk("period", e, 32'(n));
        chk("rx_tick", 32'h1, {31'h0, rx_rate_tick});
    endtask : per

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {rst_n, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} <= '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
        s_axi_wstrb <= 4'hF;
        failures = 0;
        num_checks = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(UBG_OFF_DIVISOR, 32'h0, UBG_RESP_OKAY);
        rd(UBG_OFF_CONTROL, 32'h0, UBG_RESP_OKAY);
        per(32'd64);
        $display("test reset done");
        wr(UBG_OFF_DIVISOR, 32'hFFFF_FFA5, UBG_RESP_OKAY);
        rd(UBG_OFF_DIVISOR, 32'hA5, UBG_RESP_OKAY);
        wr(UBG_OFF_CONTROL, 32'hFFFF_FFFF, UBG_RESP_OKAY);
        rd(UBG_OFF_CONTROL, 32'h20, UBG_RESP_OKAY);
        wr(UBG_OFF_STATUS, 32'h0, UBG_RESP_OKAY);
        wr(8'h0C, 32'h1, UBG_RESP_SLVERR);
        // a write with byte lane 0 off must leave the divisor alone
        s_axi_wstrb <= 4'h0;
        wr(UBG_OFF_DIVISOR, 32'h5A, UBG_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(8'h0C, 32'h0, UBG_RESP_SLVERR);
        rd(UBG_OFF_DIVISOR, 32'hA5, UBG_RESP_OKAY);
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            wr(UBG_OFF_CONTROL, 32'(cfg[c][0] << UBG_SPEED_BIT), UBG_RESP_OKAY);
            wr(UBG_OFF_DIVISOR, 32'(cfg[c][1]), UBG_RESP_OKAY);
            per(32'(cfg[c][2]));
            // two cycles after a tick: timer freshly reloaded, prescaler at one
            rd(UBG_OFF_STATUS, 32'((1 << UBG_STAT_PRE_LO) | cfg[c][1]), UBG_RESP_OKAY);
        end
        $display("test rates done");
        finish_test();
    end
endmodule : ubg_tb_top

// [hdl/ubg_pkg.sv]
package ubg_pkg;
    // register byte addresses
    localparam logic [7:0] UBG_OFF_DIVISOR = 8'h00;
    localparam logic [7:0] UBG_OFF_CONTROL = 8'h04;
    localparam logic [7:0] UBG_OFF_STATUS  = 8'h08;
    localparam int         UBG_ADDR_W      = 8;
    localparam int         UBG_DATA_W      = 32;

    // field positions
    localparam int         UBG_SPEED_BIT   = 5;
    localparam int         UBG_STAT_PRE_LO = 8;

    // values after reset
    localparam logic [7:0] UBG_DIVISOR_RST = 8'h00;
    localparam logic       UBG_SPEED_RST   = 1'b0;
    localparam logic [7:0] UBG_TIMER_RST   = 8'h00;
    localparam logic [5:0] UBG_PRE_RST     = 6'h00;

    // prescale counts: clock cycles per timer step
    localparam int         UBG_PRE_LOW     = 64;
    localparam int         UBG_PRE_HIGH    = 16;
    localparam logic [5:0] UBG_PRE_LOW_LAST  = 6'(UBG_PRE_LOW - 1);
    localparam logic [5:0] UBG_PRE_HIGH_LAST = 6'(UBG_PRE_HIGH - 1);

    // axi responses
    localparam logic [1:0] UBG_RESP_OKAY   = 2'h0;
    localparam logic [1:0] UBG_RESP_SLVERR = 2'h2;

    typedef enum logic {
        UBG_SPEED_LOW_TYPE_VAL,
        UBG_SPEED_HIGH_TYPE_VAL
    } ubg_speed_type;
endpackage : ubg_pkg

// [hdl/ubg_rate_if.sv]
`timescale 1ns/10ps
interface ubg_rate_if;
    logic [7:0] divisor;
    logic       speed_select;
    logic       rate_tick;
    logic [7:0] timer_count;
    logic [5:0] prescale_count;

    modport ctrl (
        output divisor,
        output speed_select,
        input  rate_tick,
        input  timer_count,
        input  prescale_count
    );
    modport gen (
        input  divisor,
        input  speed_select,
        output rate_tick,
        output timer_count,
        output prescale_count
    );
endinterface : ubg_rate_if

// [hdl/ubg_timer.sv]
`timescale 1ns/10ps
module ubg_timer
    import ubg_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // rate settings and results
    ubg_rate_if.gen   rate
);
    import ubg_pkg::*;

    logic [5:0] pre_cnt;
    logic [5:0] next_pre_cnt;
    logic [7:0] timer;
    logic [7:0] next_timer;
    logic       tick;
    logic       next_tick;
    logic       pre_last;

    always_comb begin
        // >= so a switch to high speed mid-count never runs the prescaler past 15
        pre_last = rate.speed_select ? (pre_cnt >= UBG_PRE_HIGH_LAST)      // [RULE3]
                                     : (pre_cnt >= UBG_PRE_LOW_LAST);      // [RULE2]
        next_pre_cnt = pre_last ? UBG_PRE_RST : 6'(pre_cnt + 6'h01);       // [RULE1]
        next_timer   = timer;
        next_tick    = 1'b0;
        if (pre_last) begin
            if (timer == 8'h00) begin
                // divisor sampled only here, so a new value waits for the reload
                next_timer = rate.divisor;                                 // [RULE9] [RULE4]
                next_tick  = 1'b1;                                         // [RULE9]
            end else begin
                next_timer = 8'(timer - 8'h01);                            // [RULE1]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_cnt <= UBG_PRE_RST;
            timer   <= UBG_TIMER_RST;
            tick    <= 1'b0;
        end else begin
            pre_cnt <= next_pre_cnt;
            timer   <= next_timer;
            tick    <= next_tick;
        end
    end

    assign rate.rate_tick      = tick;
    assign rate.timer_count    = timer;
    assign rate.prescale_count = pre_cnt;
endmodule : ubg_timer

// [hdl/ubg_top.sv]
// Notes on behaviour
// RULE1 - free running 8-bit timer sets bit rate
// RULE2 - low speed: clock over 64 times N+1
// RULE3 - high speed: clock over 16 times N+1
// RULE4 - any divisor 0 to 255 accepted
// RULE5 - divisor is a readable writable 8-bit register
// RULE6 - speed select comes from second control register
// RULE7 - speed select bit 5, resets low
// RULE8 - transmitter and receiver share one rate
// RULE9 - reload on expiry, new divisor at reload
`timescale 1ns/10ps
module ubg_top
    import ubg_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // axi4-lite write address
    input  wire logic [UBG_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // axi4-lite write data
    input  wire logic [UBG_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read address
    input  wire logic [UBG_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // axi4-lite read data
    output logic [UBG_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // shift rate to the serial engines
    output logic                       tx_rate_tick,
    output logic                       rx_rate_tick
);
    import ubg_pkg::*;

    ubg_rate_if rate_bus ();

    // register state
    logic [7:0]            divisor;
    logic [7:0]            next_divisor;
    logic                  speed_sel;
    logic                  next_speed_sel;

    // write channel state
    logic                  aw_held;
    logic                  next_aw_held;
    logic [UBG_ADDR_W-1:0] aw_addr;
    logic [UBG_ADDR_W-1:0] next_aw_addr;
    logic                  w_held;
    logic                  next_w_held;
    logic [UBG_DATA_W-1:0] w_data;
    logic [UBG_DATA_W-1:0] next_w_data;
    logic [3:0]            w_strb;
    logic [3:0]            next_w_strb;
    logic                  bvalid;
    logic                  next_bvalid;
    logic [1:0]            bresp;
    logic [1:0]            next_bresp;

    // read channel state
    logic                  rvalid;
    logic                  next_rvalid;
    logic [UBG_DATA_W-1:0] rdata;
    logic [UBG_DATA_W-1:0] next_rdata;
    logic [1:0]            rresp;
    logic [1:0]            next_rresp;

    // handshake terms
    logic                  aw_fire;
    logic                  w_fire;
    logic                  ar_fire;
    logic                  wr_go;
    logic [UBG_ADDR_W-1:0] wr_addr;
    logic [UBG_DATA_W-1:0] wr_data;
    logic [3:0]            wr_strb;

    function automatic logic reg_mapped(input logic [UBG_ADDR_W-1:0] addr);
        reg_mapped = (addr == UBG_OFF_DIVISOR) || (addr == UBG_OFF_CONTROL)
                  || (addr == UBG_OFF_STATUS);
    endfunction : reg_mapped

    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready  = !w_held && !bvalid;
    assign s_axi_arready = !rvalid;
    assign aw_fire       = s_axi_awvalid && s_axi_awready;
    assign w_fire        = s_axi_wvalid && s_axi_wready;
    assign ar_fire       = s_axi_arvalid && s_axi_arready;
    assign wr_go         = (aw_held || aw_fire) && (w_held || w_fire);
    assign wr_addr       = aw_held ? aw_addr : s_axi_awaddr;
    assign wr_data       = w_held ? w_data : s_axi_wdata;
    assign wr_strb       = w_held ? w_strb : s_axi_wstrb;

    // write path and register updates
    always_comb begin
        next_aw_held   = aw_held;
        next_aw_addr   = aw_addr;
        next_w_held    = w_held;
        next_w_data    = w_data;
        next_w_strb    = w_strb;
        next_bvalid    = bvalid;
        next_bresp     = bresp;
        next_divisor   = divisor;
        next_speed_sel = speed_sel;
        if (aw_fire) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (w_fire) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (wr_go) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = reg_mapped(wr_addr) ? UBG_RESP_OKAY : UBG_RESP_SLVERR;
            if (wr_strb[0]) begin
                if (wr_addr == UBG_OFF_DIVISOR) begin
                    next_divisor = wr_data[7:0];                           // [RULE5] [RULE4]
                end
                if (wr_addr == UBG_OFF_CONTROL) begin
                    next_speed_sel = wr_data[UBG_SPEED_BIT];               // [RULE7] [RULE6]
                end
            end
        end
    end

    // read path; status shows the live timer and prescaler
    always_comb begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (ar_fire) begin
            next_rvalid = 1'b1;
            next_rresp  = UBG_RESP_OKAY;
            next_rdata  = '0;
            unique case (s_axi_araddr)
                UBG_OFF_DIVISOR: next_rdata[7:0] = divisor;                // [RULE5]
                UBG_OFF_CONTROL: next_rdata[UBG_SPEED_BIT] = speed_sel;    // [RULE7]
                UBG_OFF_STATUS: begin
                    next_rdata[7:0] = rate_bus.timer_count;
                    next_rdata[UBG_STAT_PRE_LO +: 6] = rate_bus.prescale_count;
                end
                default: next_rresp = UBG_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            divisor   <= UBG_DIVISOR_RST;
            speed_sel <= UBG_SPEED_RST;                                    // [RULE7]
            aw_held   <= 1'b0;
            aw_addr   <= '0;
            w_held    <= 1'b0;
            w_data    <= '0;
            w_strb    <= '0;
            bvalid    <= 1'b0;
            bresp     <= UBG_RESP_OKAY;
            rvalid    <= 1'b0;
            rdata     <= '0;
            rresp     <= UBG_RESP_OKAY;
        end else begin
            divisor   <= next_divisor;
            speed_sel <= next_speed_sel;
            aw_held   <= next_aw_held;
            aw_addr   <= next_aw_addr;
            w_held    <= next_w_held;
            w_data    <= next_w_data;
            w_strb    <= next_w_strb;
            bvalid    <= next_bvalid;
            bresp     <= next_bresp;
            rvalid    <= next_rvalid;
            rdata     <= next_rdata;
            rresp     <= next_rresp;
        end
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp  = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata  = rdata;
    assign s_axi_rresp  = rresp;

    assign rate_bus.divisor      = divisor;                                // [RULE1]
    assign rate_bus.speed_select = speed_sel;                              // [RULE6]

    ubg_timer u_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .rate  (rate_bus)
    );

    // one tick feeds both directions so they can never drift apart
    assign tx_rate_tick = rate_bus.rate_tick;                              // [RULE8]
    assign rx_rate_tick = rate_bus.rate_tick;                              // [RULE8]
endmodule : ubg_top
